// [stacked_register_frame_renamer.sv]
`timescale 1ns/1ps
module stacked_register_frame_renamer #(
   parameter int POOL = stack_frame_pkg::STACK_MAX
) (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic legacyMode,
   input wire logic opValid,
   input wire stack_frame_pkg::frame_op_t opKind,
   input wire logic [stack_frame_pkg::FRAME_W-1:0] allocSof,
   input wire logic [stack_frame_pkg::FRAME_W-1:0] allocSol,
   input wire logic coverLast,
   input wire logic pfsWrEn,
   input wire logic [stack_frame_pkg::FRAME_W-1:0] pfsWrSof,
   input wire logic [stack_frame_pkg::FRAME_W-1:0] pfsWrSol,
   input wire logic [stack_frame_pkg::ADDR_W-1:0] rdAddr,
   input wire logic wrEn,
   input wire logic [stack_frame_pkg::ADDR_W-1:0] wrAddr,
   input wire logic [stack_frame_pkg::DATA_W-1:0] wrData,
   input wire logic wrToken,
   output logic [stack_frame_pkg::DATA_W-1:0] rdData,
   output logic rdToken,
   output logic [stack_frame_pkg::FRAME_W-1:0] cfmSof,
   output logic [stack_frame_pkg::FRAME_W-1:0] cfmSol,
   output logic [stack_frame_pkg::FRAME_W-1:0] pfmSof,
   output logic [stack_frame_pkg::FRAME_W-1:0] pfmSol,
   output logic [stack_frame_pkg::FRAME_W-1:0] renameBase,
   output logic illegalOpFault
);
   localparam int AW = stack_frame_pkg::ADDR_W;
   localparam int FW = stack_frame_pkg::FRAME_W;
   localparam int DW = stack_frame_pkg::DATA_W;

   // modular add within the stacked pool
   function automatic logic [FW-1:0] wrapAdd(input logic [FW-1:0] a,
                                              input logic [FW-1:0] b);
      logic [7:0] s;
      s = {1'b0, a} + {1'b0, b};
      if (s >= stack_frame_pkg::POOL_SIZE) begin
         s = s - stack_frame_pkg::POOL_SIZE;
      end
      return s[FW-1:0];
   endfunction

   function automatic logic [FW-1:0] wrapSub(input logic [FW-1:0] a,
                                              input logic [FW-1:0] b);
      logic [7:0] s;
      s = {1'b0, a} + stack_frame_pkg::POOL_SIZE - {1'b0, b};
      if (s >= stack_frame_pkg::POOL_SIZE) begin
         s = s - stack_frame_pkg::POOL_SIZE;
      end
      return s[FW-1:0];
   endfunction

   // decode
   wire logic active = opValid && !legacyMode;
   wire logic isCall = active && opKind == stack_frame_pkg::OP_CALL;
   wire logic isRet = active && opKind == stack_frame_pkg::OP_RET;
   wire logic isAlloc = active && opKind == stack_frame_pkg::OP_ALLOC;
   wire logic isCover = active && opKind == stack_frame_pkg::OP_COVER;
   wire logic allocBad = isAlloc &&
      (allocSol > allocSof ||
       allocSof > stack_frame_pkg::POOL_SIZE[FW-1:0]);
   wire logic coverBad = isCover && !coverLast;
   wire logic allocOk = isAlloc && !allocBad;

   // allocate frame is seen by writes of the same group
   wire logic [FW-1:0] effSof = allocOk ? allocSof : cfmSof;

   // address translation
   wire logic wrStacked = wrAddr >= stack_frame_pkg::STACK_FIRST;
   wire logic rdStacked = rdAddr >= stack_frame_pkg::STACK_FIRST;
   wire logic [FW-1:0] wrOff = wrAddr - stack_frame_pkg::STACK_FIRST;
   wire logic [FW-1:0] rdOff = rdAddr - stack_frame_pkg::STACK_FIRST;
   // renaming off in legacy mode
   wire logic [FW-1:0] useBase = legacyMode ?
      stack_frame_pkg::BASE_RESET : renameBase;
   wire logic [AW-1:0] wrPhys = wrStacked ?
      stack_frame_pkg::STACK_FIRST + wrapAdd(useBase, wrOff) :
      wrAddr;
   wire logic [AW-1:0] rdPhys = rdStacked ?
      stack_frame_pkg::STACK_FIRST + wrapAdd(useBase, rdOff) :
      rdAddr;
   wire logic wrOutside = wrEn && wrStacked && !legacyMode &&
      wrOff >= effSof;
   wire logic wrCommit = wrEn && !wrOutside && !allocBad;

   // next frame state
   logic [FW-1:0] next_cfmSof;
   logic [FW-1:0] next_cfmSol;
   logic [FW-1:0] next_pfmSof;
   logic [FW-1:0] next_pfmSol;
   logic [FW-1:0] next_base;

   always_comb begin
      next_cfmSof = cfmSof;
      next_cfmSol = cfmSol;
      next_pfmSof = pfsWrEn ? pfsWrSof : pfmSof;
      next_pfmSol = pfsWrEn ? pfsWrSol : pfmSol;
      next_base = renameBase;
      // current marker moves only on these frame instructions; previous marker also loads on pfsWrEn
      if (active) begin
         unique case (opKind)
            stack_frame_pkg::OP_CALL: begin
               next_pfmSof = cfmSof;
               next_pfmSol = cfmSol;
               next_cfmSof = cfmSof - cfmSol;
               next_cfmSol = stack_frame_pkg::FRAME_RESET;
               next_base = wrapAdd(renameBase, cfmSol);
            end
            stack_frame_pkg::OP_RET: begin
               next_cfmSof = pfmSof;
               next_cfmSol = pfmSol;
               next_base = wrapSub(renameBase, pfmSol);
            end
            stack_frame_pkg::OP_ALLOC: begin
               // base untouched; new registers not cleared
               if (!allocBad) begin
                  next_cfmSof = allocSof;
                  next_cfmSol = allocSol;
               end
            end
            stack_frame_pkg::OP_COVER: begin
               if (!coverBad) begin
                  next_base = wrapAdd(renameBase, cfmSof);
                  next_cfmSof = stack_frame_pkg::FRAME_RESET;
                  next_cfmSol = stack_frame_pkg::FRAME_RESET;
               end
            end
            stack_frame_pkg::OP_CLEAR_ROT: begin
               // rotating bases live elsewhere; frame sizes stay
               next_base = renameBase;
            end
            stack_frame_pkg::OP_NONE: begin
               next_base = renameBase;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         cfmSof <= stack_frame_pkg::FRAME_RESET;
         cfmSol <= stack_frame_pkg::FRAME_RESET;
         pfmSof <= stack_frame_pkg::FRAME_RESET;
         pfmSol <= stack_frame_pkg::FRAME_RESET;
         renameBase <= stack_frame_pkg::BASE_RESET;
         illegalOpFault <= 1'b0;
      end else begin
         cfmSof <= next_cfmSof;
         cfmSol <= next_cfmSol;
         pfmSof <= next_pfmSof;
         pfmSol <= next_pfmSol;
         renameBase <= next_base;
         // reads never fault
         illegalOpFault <= wrOutside || coverBad || allocBad;
      end
   end

   logic [DW:0] rdWord;

   // data out of range reads is simply whatever the pool holds
   reg_pool_mem #(
      .DEPTH(stack_frame_pkg::PHYS_DEPTH),
      .WIDTH(DW + 1),
      .AW(AW)
   ) pool (
      .clk(core_clk),
      .wrEn(wrCommit),
      .wrAddr(wrPhys),
      .wrData({wrToken, wrData}),
      .rdAddr(rdPhys),
      .rdData(rdWord)
   );

   assign rdData = rdWord[DW-1:0];
   assign rdToken = rdWord[DW];

   // checks
   sequence s_call;
      isCall;
   endsequence

   sequence s_ret;
      isRet;
   endsequence

   a_call_saves_marker: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      s_call |=> pfmSof == $past(cfmSof) && pfmSol == $past(cfmSol))
      else $error("call did not save frame marker");

   a_call_new_frame: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      s_call |=> cfmSol == 0 &&
         cfmSof == FW'($past(cfmSof) - $past(cfmSol)))
      else $error("callee frame sizes wrong");

   a_call_rename: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      s_call |=> renameBase == wrapAdd($past(renameBase), $past(cfmSol)))
      else $error("call rename base wrong");

   a_call_ret_round: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      s_call ##1 (s_ret and !pfsWrEn) |=>
         renameBase == $past(renameBase, 2) &&
         cfmSof == $past(cfmSof, 2) && cfmSol == $past(cfmSol, 2))
      else $error("return did not restore caller frame");

   a_alloc_no_rename: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      isAlloc |=> $stable(renameBase))
      else $error("allocate changed rename base");

   a_alloc_sizes: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      allocOk |=> cfmSof == $past(allocSof) && cfmSol == $past(allocSol))
      else $error("allocate sizes not taken");

   a_wr_outside_fault: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      (wrEn && wrStacked && !legacyMode && wrOff >= effSof)
         |-> !wrCommit ##1 illegalOpFault)
      else $error("outside write not faulted");

   a_read_no_fault: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      (!wrEn && !opValid) |=> !illegalOpFault)
      else $error("fault without write or op");

   a_cover_last: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      coverBad |=> illegalOpFault && $stable(cfmSof))
      else $error("misplaced cover not faulted");

   a_cover_frame: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      (isCover && coverLast) |=> cfmSof == 0 && cfmSol == 0 &&
         renameBase == wrapAdd($past(renameBase), $past(cfmSof)))
      else $error("cover frame wrong");

   a_legacy_frozen: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      (legacyMode && !pfsWrEn) |=> $stable(cfmSof) &&
         $stable(renameBase) && $stable(pfmSof))
      else $error("frame moved in legacy mode");

   a_static_direct: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      !wrStacked |-> wrPhys == wrAddr)
      else $error("static register renamed");

   a_ret_restore: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      s_ret |=> cfmSof == $past(pfmSof) &&
         cfmSol == $past(pfmSol) &&
         renameBase == wrapSub($past(renameBase), $past(pfmSol)))
      else $error("return did not restore marker");

   a_alloc_bad_hold: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      allocBad |-> !wrCommit ##1
         (illegalOpFault && $stable(cfmSof) && $stable(cfmSol)))
      else $error("bad allocate not refused");

   a_clear_rot_hold: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      (active && opKind == stack_frame_pkg::OP_CLEAR_ROT) |=>
         $stable(cfmSof) && $stable(cfmSol) && $stable(renameBase))
      else $error("clear-rotate moved the frame");

   a_idle_hold: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      !active |=> $stable(cfmSof) && $stable(cfmSol) &&
         $stable(renameBase))
      else $error("frame moved without an operation");

   a_base_in_pool: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      renameBase < FW'(POOL))
      else $error("rename base left the pool");
endmodule // stacked_register_frame_renamer

// [stack_frame_pkg.sv]
package stack_frame_pkg;
   // general register numbering
   localparam int STATIC_REGS = 32;
   localparam int STACK_MAX = 96;
   localparam int ADDR_W = 7;
   localparam int FRAME_W = 7;
   localparam int DATA_W = 64;
   localparam int PHYS_DEPTH = STATIC_REGS + STACK_MAX;
   localparam logic [ADDR_W-1:0] STACK_FIRST = 7'h20;
   localparam logic [7:0] POOL_SIZE = 8'h60;
   // reset values of the frame markers and rename base
   localparam logic [FRAME_W-1:0] FRAME_RESET = 7'h00;
   localparam logic [FRAME_W-1:0] BASE_RESET = 7'h00;

   // frame-changing operations from the pipeline
   typedef enum logic [2:0] {
      OP_NONE = 3'h0,
      OP_CALL = 3'h1,
      OP_RET = 3'h3,
      OP_ALLOC = 3'h2,
      OP_COVER = 3'h6,
      OP_CLEAR_ROT = 3'h7
   } frame_op_t;
endpackage

// [reg_pool_mem.sv]
`timescale 1ns/1ps
module reg_pool_mem #(
   parameter int DEPTH = 128,
   parameter int WIDTH = 65,
   parameter int AW = 7
) (
   input wire logic clk,
   input wire logic wrEn,
   input wire logic [AW-1:0] wrAddr,
   input wire logic [WIDTH-1:0] wrData,
   input wire logic [AW-1:0] rdAddr,
   output logic [WIDTH-1:0] rdData
);
   // no reset: fresh registers may hold anything, token included
   logic [WIDTH-1:0] store [DEPTH];

   always_ff @(posedge clk) begin
      if (wrEn) begin
         store[wrAddr] <= wrData;
      end
      rdData <= store[rdAddr];
   end
endmodule // reg_pool_mem

// [pfm_keeper.sv]
`timescale 1ns/1ps
// pipeline side: non-leaf code spills and refills its previous marker
module pfm_keeper (
   input wire logic core_clk,
   input wire logic save,
   input wire logic restore,
   input wire logic [stack_frame_pkg::FRAME_W-1:0] pfmSof,
   input wire logic [stack_frame_pkg::FRAME_W-1:0] pfmSol,
   output logic pfsWrEn,
   output logic [stack_frame_pkg::FRAME_W-1:0] pfsWrSof,
   output logic [stack_frame_pkg::FRAME_W-1:0] pfsWrSol
);
   logic [13:0] slot [8];
   logic [2:0] depth = 3'h0;
   initial {pfsWrEn, pfsWrSof, pfsWrSol} = '0;
   always @(posedge core_clk) begin
      pfsWrEn <= restore;
      if (restore) begin
         {pfsWrSof, pfsWrSol} <= slot[depth - 3'h1];
      end else begin
         // released lines toggle so stale values are never trusted
         {pfsWrSof, pfsWrSol} <= ~{pfsWrSof, pfsWrSol};
      end
      if (save) begin
         slot[depth] <= {pfmSof, pfmSol};
      end
      depth <= depth + 3'(save) - 3'(restore);
   end
endmodule // pfm_keeper

// [tb_stacked_register_frame_renamer.sv]
`timescale 1ns/1ps
module tb_stacked_register_frame_renamer;
   localparam stack_frame_pkg::frame_op_t NOP = stack_frame_pkg::OP_NONE;
   localparam stack_frame_pkg::frame_op_t CAL = stack_frame_pkg::OP_CALL;
   localparam stack_frame_pkg::frame_op_t RET = stack_frame_pkg::OP_RET;
   localparam stack_frame_pkg::frame_op_t ALC = stack_frame_pkg::OP_ALLOC;
   localparam stack_frame_pkg::frame_op_t COV = stack_frame_pkg::OP_COVER;
   localparam stack_frame_pkg::frame_op_t CLR = stack_frame_pkg::OP_CLEAR_ROT;
   logic core_clk, rst_b, legacyMode, opValid, coverLast, wrEn, wrToken;
   logic rdToken, illegalOpFault, pfsWrEn, save, restore;
   stack_frame_pkg::frame_op_t opKind;
   logic [6:0] allocSof, allocSol, rdAddr, wrAddr, cfmSof, cfmSol;
   logic [6:0] pfmSof, pfmSol, renameBase, pfsWrSof, pfsWrSol;
   logic [63:0] wrData, rdData;
   logic [64:0] got;
   logic [31:0] rnd = 32'hc204;
   int bad_count = 0, checks = 0, mSof = 0, mSol = 0, pSof = 0, pSol = 0;
   int base = 0, sSof = 0, sSol = 0;

   stacked_register_frame_renamer stacked_register_frame_renamer_inst (
      .core_clk(core_clk), .rst_b(rst_b), .legacyMode(legacyMode),
      .opValid(opValid), .opKind(opKind), .allocSof(allocSof),
      .allocSol(allocSol), .coverLast(coverLast), .pfsWrEn(pfsWrEn),
      .pfsWrSof(pfsWrSof), .pfsWrSol(pfsWrSol), .rdAddr(rdAddr),
      .wrEn(wrEn), .wrAddr(wrAddr), .wrData(wrData), .wrToken(wrToken),
      .rdData(rdData), .rdToken(rdToken), .cfmSof(cfmSof),
      .cfmSol(cfmSol), .pfmSof(pfmSof), .pfmSol(pfmSol),
      .renameBase(renameBase), .illegalOpFault(illegalOpFault));
   pfm_keeper pfm_keeper_inst (.core_clk(core_clk), .save(save),
      .restore(restore), .pfmSof(pfmSof), .pfmSol(pfmSol),
      .pfsWrEn(pfsWrEn), .pfsWrSof(pfsWrSof), .pfsWrSol(pfsWrSol));

   initial begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic int wrap(input int v);
      return (v + 96) % 96;
   endfunction

   task automatic chk(input logic [64:0] seen, input logic [64:0] exp);
      checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic final_report;
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic frame(input logic ef);
      chk({cfmSof, cfmSol}, 65'({7'(mSof), 7'(mSol)}));
      chk({pfmSof, pfmSol}, 65'({7'(pSof), 7'(pSol)}));
      chk(renameBase, 65'(base));
      chk(illegalOpFault, ef);
   endtask
   // one pipeline slot: optional frame op plus optional write
   task automatic step(input logic v, input stack_frame_pkg::frame_op_t k,
         input int so, input int sl, input logic cl, input logic we,
         input logic [6:0] wa, input logic [63:0] wd);
      logic ef;
      int ns, nl;
      @(posedge core_clk);
      opValid <= v; opKind <= k; allocSof <= 7'(so); allocSol <= 7'(sl);
      coverLast <= cl; wrEn <= we; wrAddr <= wa;
      wrData <= wd; wrToken <= wd[0];
      @(posedge core_clk);
      opValid <= 1'b0;
      wrEn <= 1'b0;
      ef = 1'b0; ns = mSof; nl = mSol;
      if (v && !legacyMode) begin
         if (k == ALC) begin
            if (sl > so || so > 96) ef = 1'b1;
            else begin ns = so; nl = sl; end
         end else if (k == CAL) begin
            pSof = mSof; pSol = mSol; base = wrap(base + mSol);
            ns = mSof - mSol; nl = 0;
         end else if (k == RET) begin
            base = wrap(base - pSol); ns = pSof; nl = pSol;
         end else if (k == COV) begin
            if (!cl) ef = 1'b1;
            else begin base = wrap(base + mSof); ns = 0; nl = 0; end
         end
      end
      if (we && !legacyMode && wa >= 7'h20 && int'(wa) - 32 >= ns) ef = 1'b1;
      mSof = ns; mSol = nl;
      #1 frame(ef);
   endtask
   task automatic rd(input logic [6:0] a);
      @(posedge core_clk);
      rdAddr <= a;
      @(posedge core_clk);
      #1 got = {rdToken, rdData};
      chk(illegalOpFault, 1'b0);
   endtask
   task automatic pr(input logic sv, input logic rs);
      @(posedge core_clk);
      save <= sv; restore <= rs;
      @(posedge core_clk);
      save <= 1'b0; restore <= 1'b0;
      @(posedge core_clk);
   endtask

   initial begin
      {rst_b, legacyMode, opValid, coverLast, wrEn, wrToken} = '0;
      {save, restore, allocSof, allocSol, rdAddr, wrAddr, wrData} = '0;
      opKind = NOP;
      repeat (16) @(posedge core_clk);
      rst_b <= 1'b1;
      #1 frame(1'b0);
      $display("test reset done");
      step(1, ALC, 10, 4, 0, 1, 7'h29, 64'h1111);
      step(0, NOP, 0, 0, 0, 1, 7'h1f, 64'h2222);
      step(0, NOP, 0, 0, 0, 1, 7'h2a, 64'h3333);
      rd(7'h29); chk(got, {1'b1, 64'h1111});
      rd(7'h1f); chk(got, {1'b0, 64'h2222});
      rd(7'h2a);
      $display("test frame bounds done");
      step(1, CAL, 0, 0, 0, 0, 7'h00, 64'h0);
      rd(7'h25); chk(got, {1'b1, 64'h1111});
      pr(1, 0); sSof = pSof; sSol = pSol;
      step(1, ALC, 8, 3, 0, 1, 7'h27, 64'h4444);
      step(1, CAL, 0, 0, 0, 0, 7'h00, 64'h0);
      step(1, RET, 0, 0, 0, 0, 7'h00, 64'h0);
      pr(0, 1); pSof = sSof; pSol = sSol;
      #1 frame(1'b0);
      step(1, RET, 0, 0, 0, 0, 7'h00, 64'h0);
      rd(7'h29); chk(got, {1'b1, 64'h1111});
      $display("test call chain done");
      step(1, COV, 0, 0, 1, 0, 7'h00, 64'h0);
      step(1, COV, 0, 0, 0, 0, 7'h00, 64'h0);
      step(1, CLR, 0, 0, 0, 1, 7'h20, 64'h5);
      @(posedge core_clk) legacyMode <= 1'b1;
      step(1, CAL, 0, 0, 0, 1, 7'h60, 64'h6);
      rd(7'h60); chk(got, {1'b0, 64'h6});
      @(posedge core_clk) legacyMode <= 1'b0;
      step(1, RET, 0, 0, 0, 0, 7'h00, 64'h0);
      // call then return in adjacent cycles
      @(posedge core_clk) opValid <= 1'b1;
      opKind <= CAL;
      @(posedge core_clk) opKind <= RET;
      @(posedge core_clk) opValid <= 1'b0;
      pSof = mSof; pSol = mSol;
      #1 frame(1'b0);
      $display("test cover and legacy done");
      repeat (80) begin
         rnd = lfsr(rnd);
         case (rnd[1:0])
            2'h0: step(1, ALC, rnd[8:2], rnd[14:9], 0, 0, 7'h0, 64'h0);
            2'h1: step(1, CAL, 0, 0, 0, 0, 7'h0, 64'h0);
            2'h2: step(1, RET, 0, 0, 0, 0, 7'h0, 64'h0);
            default: step(0, NOP, 0, 0, 0, 1, rnd[22:16], {rnd, ~rnd});
         endcase
      end
      $display("test random ops done");
      final_report();
   end

   // run needs about a microsecond; this margin only catches a hang
   initial begin
      #100000;
      bad_count++;
      final_report();
   end
endmodule // tb_stacked_register_frame_renamer
